/* File: verilog/meq_defs.svh */
`ifndef MEQ_DEFS_SVH
`define MEQ_DEFS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MEQ_OFF_SEL_A 8'h00
`define MEQ_OFF_SEL_B 8'h04
`define MEQ_OFF_CFG0 8'h10
`define MEQ_OFF_CNT0 8'h14
`define MEQ_OFF_CFG1 8'h18
`define MEQ_OFF_CNT1 8'h1C
`define MEQ_RST_WORD 32'h0000_0000
`define MEQ_RESP_OK 2'h0
`define MEQ_RESP_ERR 2'h2
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MEQ_CODE_HI 31
`define MEQ_CODE_LO 25
`define MEQ_MASK_HI 24
`define MEQ_MASK_LO 9
`define MEQ_CSEL_HI 15
`define MEQ_CSEL_LO 13
`define MEQ_CFG_EN 12
`define MEQ_CFG_USE_B 11
`define MEQ_CFG_RETIRE 10
// ----------------------------------------
// Event codes and counter select codes
// ----------------------------------------
`define MEQ_EV_STORE 7'h05
`define MEQ_EV_LOAD 7'h03
`define MEQ_EV_WALK 7'h01
`define MEQ_EV_CACHE 7'h0C
`define MEQ_EV_ALLOC 7'h03
`define MEQ_CS_REPLAY 3'h2
`define MEQ_CS_WALK 3'h4
`define MEQ_CS_CACHE 3'h7
`define MEQ_CS_ALLOC 3'h6
`endif

/* File: verilog/meq_pkg.sv */
package meq_pkg;
	// Bus slave state
	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wr_pulse;
		logic bvalid;
		logic [1:0] bresp;
		logic [7:0] araddr;
		logic rd_req;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} meq_axil_t;
	// Register file state
	typedef struct packed {
		logic [31:0] sel_a;
		logic [31:0] sel_b;
		logic [1:0][31:0] cfg;
		logic [1:0][31:0] cnt;
	} meq_regs_t;
endpackage

/* File: verilog/meq_event_match.sv */
`include "meq_defs.svh"
module meq_event_match (
	input wire logic [6:0] code, // Event select code
	input wire logic [15:0] mask, // Qualifying mask
	input wire logic [2:0] csel, // Counter select code
	input wire logic st_split, // Split store replay
	input wire logic [5:0] ld_cause, // Load replay causes
	input wire logic walk_d, // Data walk
	input wire logic walk_i, // Instruction walk
	input wire logic cr_valid, // Cache reference seen
	input wire logic cr_load, // Reference is a load
	input wire logic cr_own, // Reference is ownership req
	input wire logic cr_l3, // Third level, else second
	input wire logic [2:0] cr_hit, // Hit S/E/M one-hot
	input wire logic cr_miss, // Lookup missed
	input wire logic cr_wb, // Writeback lookup
	input wire logic al_valid, // Queue allocation
	input wire logic [4:0] al_req, // Request type field
	input wire logic al_read, // Read entry
	input wire logic al_write, // Write entry
	input wire logic [1:0] al_mem, // Memory type field
	output logic hit // Selected event qualified
);
	logic cr_rd;
	logic req_any;
	// ----------------------------------------
	// Per event qualification
	// ----------------------------------------
	// Status is taken live, so a reclassified prefetch counts as now
	always_comb begin
		cr_rd = cr_valid & (cr_load | cr_own);
		req_any = |(mask[4:0] & al_req);
		hit = 1'b0;
		if (code == `MEQ_EV_STORE && csel == `MEQ_CS_REPLAY) begin
			hit = mask[1] & st_split;
		end else if (code == `MEQ_EV_LOAD && csel == `MEQ_CS_REPLAY) begin
			hit = (mask[1] & ld_cause[1]) | (mask[3] & ld_cause[3])
				| (mask[4] & ld_cause[4])
				| (mask[5] & ld_cause[5]);
		end else if (code == `MEQ_EV_WALK && csel == `MEQ_CS_WALK) begin
			hit = (mask[0] & walk_d) | (mask[1] & walk_i);
		end else if (code == `MEQ_EV_CACHE && csel == `MEQ_CS_CACHE) begin
			hit = (cr_rd & ~cr_l3 & |(mask[2:0] & cr_hit))
				| (cr_rd & cr_l3 & |(mask[5:3] & cr_hit))
				| (cr_rd & cr_miss & ~cr_l3 & mask[8])
				| (cr_rd & cr_miss & cr_l3 & mask[9])
				| (cr_valid & cr_wb & cr_miss & ~cr_l3 & mask[10]);
		end else if (code == `MEQ_EV_ALLOC && csel == `MEQ_CS_ALLOC) begin
			// One count per allocation, retries included
			hit = al_valid
				& (req_any | (mask[5] & al_read)
				| (mask[6] & al_write) | |(mask[8:7] & al_mem));
		end
	end
endmodule // meq_event_match

/* File: verilog/meq_axil.sv */
`include "meq_defs.svh"
module meq_axil (
	input wire logic clk, // Core clock
	input wire logic rst, // Sync reset
	input wire logic ce, // Clock enable
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [7:0] awaddr, // Write address
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Byte strobes
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	output logic [1:0] bresp, // Write response
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	input wire logic [7:0] araddr, // Read address
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic wr_pulse, // Apply write now
	output logic [7:0] wr_addr, // Held write address
	output logic [31:0] wr_data, // Held write data
	output logic [3:0] wr_strb, // Held strobes
	input wire logic wr_err, // Write address unmapped
	output logic [7:0] rd_addr, // Held read address
	input wire logic [31:0] rd_data, // Data at rd_addr
	input wire logic rd_err // Read address unmapped
);
	meq_pkg::meq_axil_t s;
	meq_pkg::meq_axil_t next_s;
	// ----------------------------------------
	// Handshakes, one write and one read open
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.wr_pulse = 1'b0;
		next_s.rd_req = 1'b0;
		if (awvalid && s.awready) begin
			next_s.awready = 1'b0;
			next_s.aw_got = 1'b1;
			next_s.awaddr = awaddr;
		end
		if (wvalid && s.wready) begin
			next_s.wready = 1'b0;
			next_s.w_got = 1'b1;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
		end
		if (s.aw_got && s.w_got) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.wr_pulse = 1'b1;
			next_s.bvalid = 1'b1;
			next_s.bresp = wr_err ? `MEQ_RESP_ERR : `MEQ_RESP_OK;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end
		if (arvalid && s.arready) begin
			next_s.arready = 1'b0;
			next_s.araddr = araddr;
			next_s.rd_req = 1'b1;
		end
		// Data captured a cycle late so decode sees a held address
		if (s.rd_req) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_data;
			next_s.rresp = rd_err ? `MEQ_RESP_ERR : `MEQ_RESP_OK;
		end
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
	end
	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else if (ce) begin
			s <= next_s;
		end
	end
	// Outputs straight from state
	assign awready = s.awready;
	assign wready = s.wready;
	assign arready = s.arready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign wr_pulse = s.wr_pulse;
	assign wr_addr = s.awaddr;
	assign wr_data = s.wdata;
	assign wr_strb = s.wstrb;
	assign rd_addr = s.araddr;
endmodule // meq_axil

/* File: verilog/meq_top.sv */
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`include "meq_defs.svh"
module meq_top (
	input wire logic SYS_CLK, // Core clock
	input wire logic SYS_RST, // Sync reset, high
	input wire logic CE, // Freezes all state when low
	input wire logic AWVALID, // Write address valid
	output logic AWREADY, // Write address ready
	input wire logic [7:0] AWADDR, // Write address
	input wire logic WVALID, // Write data valid
	output logic WREADY, // Write data ready
	input wire logic [31:0] WDATA, // Write data
	input wire logic [3:0] WSTRB, // Byte strobes
	output logic BVALID, // Write response valid
	input wire logic BREADY, // Write response ready
	output logic [1:0] BRESP, // Write response
	input wire logic ARVALID, // Read address valid
	output logic ARREADY, // Read address ready
	input wire logic [7:0] ARADDR, // Read address
	output logic RVALID, // Read data valid
	input wire logic RREADY, // Read data ready
	output logic [31:0] RDATA, // Read data
	output logic [1:0] RRESP, // Read response
	input wire logic STORE_SPLIT_REPLAY, // Split store replayed
	input wire logic [5:0] LOAD_REPLAY_CAUSE, // Load replay causes
	input wire logic WALK_DATA_MISS, // Walk for data miss
	input wire logic WALK_INSTR_MISS, // Walk for instr miss
	input wire logic CR_VALID, // Cache reference seen
	input wire logic CR_LOAD, // Reference is a load
	input wire logic CR_OWN_REQ, // Ownership request
	input wire logic CR_L3, // Third level lookup
	input wire logic [2:0] CR_HIT, // Hit S/E/M one-hot
	input wire logic CR_MISS, // Lookup missed
	input wire logic CR_WB_LOOKUP, // Writeback lookup
	input wire logic AL_VALID, // Queue allocation
	input wire logic [4:0] AL_REQ, // Request type
	input wire logic AL_READ, // Read entry
	input wire logic AL_WRITE, // Write entry
	input wire logic [1:0] AL_MEM // Memory type
);
	meq_pkg::meq_regs_t r;
	meq_pkg::meq_regs_t next_r;
	logic wr_pulse;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	logic [1:0] inc;
	logic [1:0][31:0] sel;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	meq_axil u_axil (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.ce(CE),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.awaddr(AWADDR),
		.wvalid(WVALID),
		.wready(WREADY),
		.wdata(WDATA),
		.wstrb(WSTRB),
		.bvalid(BVALID),
		.bready(BREADY),
		.bresp(BRESP),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.araddr(ARADDR),
		.rvalid(RVALID),
		.rready(RREADY),
		.rdata(RDATA),
		.rresp(RRESP),
		.wr_pulse(wr_pulse),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// Byte lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = val[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------
	// Event qualification per counter
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ctr
			logic hit;
			logic blocked;
			// Counter picks control a or b by its own config
			assign sel[gi] = r.cfg[gi][`MEQ_CFG_USE_B] ? r.sel_b : r.sel_a;
			meq_event_match u_match (
				.code(sel[gi][`MEQ_CODE_HI:`MEQ_CODE_LO]),
				.mask(sel[gi][`MEQ_MASK_HI:`MEQ_MASK_LO]),
				.csel(r.cfg[gi][`MEQ_CSEL_HI:`MEQ_CSEL_LO]),
				.st_split(STORE_SPLIT_REPLAY),
				.ld_cause(LOAD_REPLAY_CAUSE),
				.walk_d(WALK_DATA_MISS),
				.walk_i(WALK_INSTR_MISS),
				.cr_valid(CR_VALID),
				.cr_load(CR_LOAD),
				.cr_own(CR_OWN_REQ),
				.cr_l3(CR_L3),
				.cr_hit(CR_HIT),
				.cr_miss(CR_MISS),
				.cr_wb(CR_WB_LOOKUP),
				.al_valid(AL_VALID),
				.al_req(AL_REQ),
				.al_read(AL_READ),
				.al_write(AL_WRITE),
				.al_mem(AL_MEM),
				.hit(hit)
			);
			// Retirement store counting is only valid through control b
			assign blocked = r.cfg[gi][`MEQ_CFG_RETIRE]
				& ~r.cfg[gi][`MEQ_CFG_USE_B]
				& (sel[gi][`MEQ_CODE_HI:`MEQ_CODE_LO] == `MEQ_EV_STORE);
			assign inc[gi] = r.cfg[gi][`MEQ_CFG_EN] & hit & ~blocked;
		end
	endgenerate

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	always_comb begin
		rd_err = 1'b0;
		rd_data = `MEQ_RST_WORD;
		if (rd_addr == `MEQ_OFF_SEL_A) begin
			rd_data = r.sel_a;
		end else if (rd_addr == `MEQ_OFF_SEL_B) begin
			rd_data = r.sel_b;
		end else if (rd_addr == `MEQ_OFF_CFG0) begin
			rd_data = r.cfg[0];
		end else if (rd_addr == `MEQ_OFF_CNT0) begin
			rd_data = r.cnt[0];
		end else if (rd_addr == `MEQ_OFF_CFG1) begin
			rd_data = r.cfg[1];
		end else if (rd_addr == `MEQ_OFF_CNT1) begin
			rd_data = r.cnt[1];
		end else begin
			rd_err = 1'b1;
		end
	end

	// Unmapped writes answer with an error and change nothing
	always_comb begin
		wr_err = 1'b1;
		if (wr_addr == `MEQ_OFF_SEL_A) begin
			wr_err = 1'b0;
		end else if (wr_addr == `MEQ_OFF_SEL_B) begin
			wr_err = 1'b0;
		end else if (wr_addr == `MEQ_OFF_CFG0 || wr_addr == `MEQ_OFF_CNT0) begin
			wr_err = 1'b0;
		end else if (wr_addr == `MEQ_OFF_CFG1 || wr_addr == `MEQ_OFF_CNT1) begin
			wr_err = 1'b0;
		end
	end

	// ----------------------------------------
	// Register and counter update
	// ----------------------------------------
	// Software load of a counter wins over an increment that cycle
	always_comb begin
		next_r = r;
		for (int i = 0; i < 2; i++) begin
			if (inc[i]) begin
				next_r.cnt[i] = r.cnt[i] + 32'h0000_0001;
			end
		end
		if (wr_pulse) begin
			if (wr_addr == `MEQ_OFF_SEL_A) begin
				next_r.sel_a = merge(r.sel_a, wr_data, wr_strb);
			end else if (wr_addr == `MEQ_OFF_SEL_B) begin
				next_r.sel_b = merge(r.sel_b, wr_data, wr_strb);
			end else if (wr_addr == `MEQ_OFF_CFG0) begin
				next_r.cfg[0] = merge(r.cfg[0], wr_data, wr_strb);
			end else if (wr_addr == `MEQ_OFF_CNT0) begin
				next_r.cnt[0] = merge(r.cnt[0], wr_data, wr_strb);
			end else if (wr_addr == `MEQ_OFF_CFG1) begin
				next_r.cfg[1] = merge(r.cfg[1], wr_data, wr_strb);
			end else if (wr_addr == `MEQ_OFF_CNT1) begin
				next_r.cnt[1] = merge(r.cnt[1], wr_data, wr_strb);
			end
		end
	end

	// State register
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			r <= '0;
		end else if (CE) begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);

	logic [6:0] code0;
	logic [15:0] mask0;
	logic [2:0] csel0;
	logic en0;
	logic cnt0_wr;
	assign code0 = sel[0][`MEQ_CODE_HI:`MEQ_CODE_LO];
	assign mask0 = sel[0][`MEQ_MASK_HI:`MEQ_MASK_LO];
	assign csel0 = r.cfg[0][`MEQ_CSEL_HI:`MEQ_CSEL_LO];
	assign en0 = r.cfg[0][`MEQ_CFG_EN];
	assign cnt0_wr = wr_pulse && wr_addr == `MEQ_OFF_CNT0;

	property p_store;
		en0 && code0 == 7'h05 && csel0 == 3'h2 && mask0[1]
			&& STORE_SPLIT_REPLAY && !r.cfg[0][`MEQ_CFG_RETIRE] |-> inc[0];
	endproperty
	a_store: assert property (p_store)
		else $error("store replay missed");

	property p_retire;
		r.cfg[0][`MEQ_CFG_RETIRE] && !r.cfg[0][`MEQ_CFG_USE_B]
			&& code0 == 7'h05 |-> !inc[0];
	endproperty
	a_retire: assert property (p_retire)
		else $error("retire via a counted");

	property p_load;
		en0 && code0 == 7'h03 && csel0 == 3'h2
			&& |(mask0[5:1] & LOAD_REPLAY_CAUSE[5:1] & 5'h1D) |-> inc[0];
	endproperty
	a_load: assert property (p_load)
		else $error("load replay missed");

	property p_walk;
		en0 && code0 == 7'h01 && csel0 == 3'h4
			&& !(mask0[0] && WALK_DATA_MISS) && !(mask0[1] && WALK_INSTR_MISS)
			|-> !inc[0];
	endproperty
	a_walk: assert property (p_walk) else $error("walk miscounted");

	property p_l2hit;
		en0 && code0 == 7'h0C && csel0 == 3'h7 && CR_VALID && CR_LOAD
			&& !CR_L3 && mask0[2] && CR_HIT[2] |-> inc[0];
	endproperty
	a_l2hit: assert property (p_l2hit) else $error("l2 hit missed");

	property p_alloc;
		en0 && code0 == 7'h03 && csel0 == 3'h6 && !AL_VALID |-> !inc[0];
	endproperty
	a_alloc: assert property (p_alloc)
		else $error("alloc without entry");

	property p_alloc_rd;
		en0 && code0 == 7'h03 && csel0 == 3'h6 && AL_VALID && mask0[5]
			&& AL_READ |-> inc[0];
	endproperty
	a_alloc_rd: assert property (p_alloc_rd)
		else $error("read alloc missed");

	property p_count;
		inc[0] && CE && !cnt0_wr |=> r.cnt[0] == $past(r.cnt[0]) + 32'h1;
	endproperty
	a_count: assert property (p_count)
		else $error("counter not stepped");

	property p_idle;
		!en0 && CE && !cnt0_wr |=> $stable(r.cnt[0]);
	endproperty
	a_idle: assert property (p_idle)
		else $error("disabled counter moved");

	property p_bhold;
		BVALID && !BREADY |=> BVALID && $stable(BRESP);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");

	c_store: cover property (inc[0] && code0 == 7'h05);
	c_walk: cover property (inc[0] && WALK_INSTR_MISS);
	c_alloc: cover property (inc[0] && AL_VALID ##1 inc[0] && AL_VALID);
	c_err: cover property (RVALID && RRESP == 2'h2);
endmodule // meq_top

/* File: tb/meq_event_src.sv */
// ----------------------------------------
// Pipeline, cache and bus event source
// ----------------------------------------
module meq_event_src (
	input wire logic clk, // Core clock
	input wire logic rst, // Sync reset
	input wire logic go, // Present vector next cycle
	input wire logic [27:0] vec, // Flattened event lines
	output logic [27:0] ev // Registered event lines
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines are per-cycle levels, so idle means all low
	always_ff @(posedge clk) begin
		ev <= (rst || !go) ? 28'h0000000 : vec;
	end
endmodule // meq_event_src

/* File: tb/tb_top.sv */
`include "meq_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic ce = 1'h1;
	logic go = 1'h0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic [27:0] vec = 28'h0;
	logic [27:0] ev;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [7:0] offs [6] = '{`MEQ_OFF_SEL_A, `MEQ_OFF_SEL_B, `MEQ_OFF_CFG0,
		`MEQ_OFF_CNT0, `MEQ_OFF_CFG1, `MEQ_OFF_CNT1};
	// Event code, select code, mask bit, event lines
	logic [41:0] tbl [25] = '{
		{7'h05, 3'h2, 4'h1, 28'h8000000},
		{7'h03, 3'h2, 4'h1, 28'h0400000}, {7'h03, 3'h2, 4'h3, 28'h1000000},
		{7'h03, 3'h2, 4'h4, 28'h2000000}, {7'h03, 3'h2, 4'h5, 28'h4000000},
		{7'h01, 3'h4, 4'h0, 28'h0100000}, {7'h01, 3'h4, 4'h1, 28'h0080000},
		{7'h0C, 3'h7, 4'h0, 28'h0061000}, {7'h0C, 3'h7, 4'h1, 28'h0052000},
		{7'h0C, 3'h7, 4'h2, 28'h0064000}, {7'h0C, 3'h7, 4'h3, 28'h0059000},
		{7'h0C, 3'h7, 4'h4, 28'h006A000}, {7'h0C, 3'h7, 4'h5, 28'h005C000},
		{7'h0C, 3'h7, 4'h8, 28'h0060800}, {7'h0C, 3'h7, 4'h9, 28'h0058800},
		{7'h0C, 3'h7, 4'hA, 28'h0040C00},
		{7'h03, 3'h6, 4'h0, 28'h0000210}, {7'h03, 3'h6, 4'h1, 28'h0000220},
		{7'h03, 3'h6, 4'h2, 28'h0000240}, {7'h03, 3'h6, 4'h3, 28'h0000280},
		{7'h03, 3'h6, 4'h4, 28'h0000300}, {7'h03, 3'h6, 4'h5, 28'h0000208},
		{7'h03, 3'h6, 4'h6, 28'h0000204}, {7'h03, 3'h6, 4'h7, 28'h0000201},
		{7'h03, 3'h6, 4'h8, 28'h0000202}};
	// Free-running core clock
	always #4 clk = ~clk;
	// ----------------------------------------
	// Design and event source
	// ----------------------------------------
	meq_top dut (
		.SYS_CLK(clk), .SYS_RST(rst), .CE(ce),
		.AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
		.WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
		.BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
		.ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
		.RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
		.STORE_SPLIT_REPLAY(ev[27]), .LOAD_REPLAY_CAUSE(ev[26:21]),
		.WALK_DATA_MISS(ev[20]), .WALK_INSTR_MISS(ev[19]),
		.CR_VALID(ev[18]), .CR_LOAD(ev[17]), .CR_OWN_REQ(ev[16]),
		.CR_L3(ev[15]), .CR_HIT(ev[14:12]), .CR_MISS(ev[11]),
		.CR_WB_LOOKUP(ev[10]), .AL_VALID(ev[9]), .AL_REQ(ev[8:4]),
		.AL_READ(ev[3]), .AL_WRITE(ev[2]), .AL_MEM(ev[1:0])
	);
	meq_event_src src (.clk(clk), .rst(rst), .go(go), .vec(vec), .ev(ev));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [33:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		@(posedge clk);
		awvalid <= 1'h1;
		awaddr <= a;
		wvalid <= 1'h1;
		wdata <= d;
		wstrb <= s;
		// Ready sometimes late, so a held response is exercised
		bready <= 1'($urandom % 2);
		bq.push_back(er);
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid && !bready) bready <= 1'h1;
		end while (!(bvalid && bready));
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] exp);
		@(posedge clk);
		arvalid <= 1'h1;
		araddr <= a;
		rready <= 1'h1;
		rq.push_back(exp);
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (!(rvalid && rready));
		rready <= 1'h0;
	endtask
	// Back-to-back event cycles, n of them
	task automatic pulse(input logic [27:0] v, input int n);
		@(posedge clk);
		go <= 1'h1;
		vec <= v;
		repeat (n) @(posedge clk);
		go <= 1'h0;
	endtask
	// Compare answers in order; timeout guards against a hung handshake
	always @(posedge clk) begin
		if (bvalid && bready) begin
			chk("bresp", 34'(bresp), 34'(bq.pop_front()));
		end
		if (rvalid && rready) begin
			chk("rdata", {rresp, rdata}, rq.pop_front());
		end
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [41:0] e;
		logic [31:0] r1, r2;
		int n;
		void'($urandom(86747));
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		// Reset values, unmapped access, byte strobes
		foreach (offs[i]) rd(offs[i], 34'h0);
		rd(8'h08, {`MEQ_RESP_ERR, 32'h0});
		r1 = $urandom;
		r2 = $urandom;
		wr(8'h0C, r1, 4'hF, `MEQ_RESP_ERR);
		wr(`MEQ_OFF_SEL_A, r1, 4'hF, `MEQ_RESP_OK);
		wr(`MEQ_OFF_SEL_A, r2, 4'h5, `MEQ_RESP_OK);
		rd(`MEQ_OFF_SEL_A, {2'h0, r1[31:24], r2[23:16], r1[15:8], r2[7:0]});
		// Each event and mask bit: counted alone, ignored when masked off
		foreach (tbl[i]) begin
			e = tbl[i];
			n = 1 + $urandom % 4;
			wr(`MEQ_OFF_SEL_A, {e[41:35], 16'h0001 << e[31:28], 9'h000},
				4'hF, `MEQ_RESP_OK);
			wr(`MEQ_OFF_CFG0, {16'h0, e[34:32], 13'h1000}, 4'hF, `MEQ_RESP_OK);
			wr(`MEQ_OFF_CNT0, 32'h0, 4'hF, `MEQ_RESP_OK);
			pulse(e[27:0], n);
			wr(`MEQ_OFF_SEL_A, {e[41:35], ~(16'h0001 << e[31:28]) & 16'h07FF,
				9'h000}, 4'hF, `MEQ_RESP_OK);
			pulse(e[27:0], 1);
			repeat (3) @(posedge clk);
			rd(`MEQ_OFF_CNT0, {2'h0, 32'(n)});
		end
		// Several causes in one cycle still add one
		wr(`MEQ_OFF_SEL_A, {7'h03, 16'h001A, 9'h000}, 4'hF, `MEQ_RESP_OK);
		wr(`MEQ_OFF_CFG0, {16'h0, 3'h2, 13'h1000}, 4'hF, `MEQ_RESP_OK);
		wr(`MEQ_OFF_CNT0, 32'h0, 4'hF, `MEQ_RESP_OK);
		pulse(28'h3400000, 2);
		repeat (3) @(posedge clk);
		rd(`MEQ_OFF_CNT0, 34'h2);
		// Retirement counting of store replays only through control b
		wr(`MEQ_OFF_SEL_A, {7'h05, 16'h0002, 9'h000}, 4'hF, `MEQ_RESP_OK);
		wr(`MEQ_OFF_SEL_B, {7'h05, 16'h0002, 9'h000}, 4'hF, `MEQ_RESP_OK);
		wr(`MEQ_OFF_CFG0, {16'h0, 3'h2, 13'h1400}, 4'hF, `MEQ_RESP_OK);
		wr(`MEQ_OFF_CFG1, {16'h0, 3'h2, 13'h1C00}, 4'hF, `MEQ_RESP_OK);
		wr(`MEQ_OFF_CNT0, 32'h0, 4'hF, `MEQ_RESP_OK);
		pulse(28'h8000000, 3);
		repeat (3) @(posedge clk);
		rd(`MEQ_OFF_CNT0, 34'h0);
		rd(`MEQ_OFF_CNT1, 34'h3);
		// Frozen clock enable swallows events, then counting resumes
		@(posedge clk);
		ce <= 1'h0;
		pulse(28'h8000000, 2);
		repeat (3) @(posedge clk);
		ce <= 1'h1;
		rd(`MEQ_OFF_CNT1, 34'h3);
		pulse(28'h8000000, 1);
		repeat (3) @(posedge clk);
		rd(`MEQ_OFF_CNT1, 34'h4);
		wrap_up();
	end
endmodule // tb_top
